// File: design/pfmux_regs.vh
// Register offsets, field positions and reset values of the port function mux
`ifndef PFMUX_REGS_VH
`define PFMUX_REGS_VH
// Register offsets; the printed offsets are not all multiples of four, so they
// are indexes and the byte address is four times the index
`define PFMUX_IDX_PORT1_SEL   8'h91
`define PFMUX_IDX_PORT3_SEL   8'h93
`define PFMUX_IDX_PORT4_SEL   8'h94
`define PFMUX_ADDR_W          10
`define PFMUX_RESET_VAL       8'h00
`define PFMUX_P1_IN_RESET     4'h0
`define PFMUX_ANALOG_RESET    4'h0
`define PFMUX_P3_IN_RESET     6'h00
`define PFMUX_I2C_IDLE        1'b1
// Writable bit masks; reserved bits read as zero
`define PFMUX_PORT1_MASK      8'hf0
`define PFMUX_PORT3_MASK      8'hc0
`define PFMUX_PORT4_MASK      8'hf8
// Field positions
`define PFMUX_P3_SCL_BIT      7
`define PFMUX_P3_SDA_BIT      6
`define PFMUX_ZERO_WORD       32'h00000000
`endif

// File: design/pfmux_top.v
// Port 1, 3 and 4 pin function multiplexer with a Wishbone register slave
`include "pfmux_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module pfmux_top (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Port 1 GPIO side
  input  wire [7:0]  p1_gpio_out_i,
  input  wire [7:0]  p1_gpio_oe_i,
  output reg  [7:0]  p1_gpio_in_o,
  // Port 1 peripherals
  input  wire [1:0]  timer2_en_i,
  input  wire [1:0]  timer2_out_i,
  input  wire [1:0]  timer2_oe_i,
  input  wire [1:0]  uart2_en_i,
  input  wire [1:0]  uart2_out_i,
  input  wire [1:0]  uart2_oe_i,
  output reg  [3:0]  p1_periph_in_o,
  output reg  [3:0]  analog_input_select_o,
  // Port 3 GPIO side
  input  wire [7:0]  p3_gpio_out_i,
  input  wire [7:0]  p3_gpio_oe_i,
  output reg  [7:0]  p3_gpio_in_o,
  // Port 3 peripherals: uart, interrupts, timers (bits 5..0)
  input  wire [5:0]  p3_periph_en_i,
  input  wire [5:0]  p3_periph_out_i,
  input  wire [5:0]  p3_periph_oe_i,
  output reg  [5:0]  p3_periph_in_o,
  // I2C unit, open drain style
  input  wire        i2c_scl_out_i,
  input  wire        i2c_scl_oe_i,
  input  wire        i2c_sda_out_i,
  input  wire        i2c_sda_oe_i,
  output reg         i2c_scl_in_o,
  output reg         i2c_sda_in_o,
  // Port 4 GPIO side and PWM
  input  wire [7:0]  p4_gpio_out_i,
  input  wire [7:0]  p4_gpio_oe_i,
  output reg  [7:0]  p4_gpio_in_o,
  input  wire [4:0]  pwm_out_i,
  // Pins
  input  wire [7:0]  p1_pin_i,
  output reg  [7:0]  p1_pin_o,
  output reg  [7:0]  p1_pin_oe_o,
  input  wire [7:0]  p3_pin_i,
  output reg  [7:0]  p3_pin_o,
  output reg  [7:0]  p3_pin_oe_o,
  input  wire [7:0]  p4_pin_i,
  output reg  [7:0]  p4_pin_o,
  output reg  [7:0]  p4_pin_oe_o
);

  // ==========================================================
  // Register bus
  // ==========================================================
  reg  [7:0] port1_function_select_q;
  reg  [7:0] port3_function_select_q;
  reg  [7:0] port4_function_select_q;

  // Byte lane 0 carries every select register; masked bits stay zero
  function [7:0] pfmux_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input       lane_en;
    input [7:0] mask;
    begin
      pfmux_merge = (lane_en ? new_v : old_v) & mask;
    end
  endfunction

  // Per-bit choice between a peripheral and the port latch
  function [7:0] pfmux_pick;
    input [7:0] take;
    input [7:0] alt_v;
    input [7:0] gpio_v;
    begin
      pfmux_pick = (take & alt_v) | (~take & gpio_v);
    end
  endfunction

  // Read value of the addressed select register; zero when unmapped
  function [7:0] pfmux_read;
    input       sel_p1;
    input       sel_p3;
    input       sel_p4;
    input [7:0] v1;
    input [7:0] v3;
    input [7:0] v4;
    begin
      if (sel_p1)
        pfmux_read = v1;
      else if (sel_p3)
        pfmux_read = v3;
      else if (sel_p4)
        pfmux_read = v4;
      else
        pfmux_read = `PFMUX_RESET_VAL;
    end
  endfunction

  wire        wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0]  wb_idx  = wb_adr_i[`PFMUX_ADDR_W-1:2];
  wire        hit_p1  = (wb_idx == `PFMUX_IDX_PORT1_SEL);
  wire        hit_p3  = (wb_idx == `PFMUX_IDX_PORT3_SEL);
  wire        hit_p4  = (wb_idx == `PFMUX_IDX_PORT4_SEL);
  // Writes land at the edge where the master sees ack high
  wire        do_wr   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire        do_rd   = wb_req & ~wb_we_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      port1_function_select_q <= `PFMUX_RESET_VAL;
      port3_function_select_q <= `PFMUX_RESET_VAL;
      port4_function_select_q <= `PFMUX_RESET_VAL;
      wb_ack_o                <= 1'b0;
      wb_dat_o                <= `PFMUX_ZERO_WORD;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= `PFMUX_ZERO_WORD;
      if (do_rd)
        wb_dat_o[7:0] <= pfmux_read(hit_p1, hit_p3, hit_p4,
          port1_function_select_q, port3_function_select_q,
          port4_function_select_q);
      if (do_wr & hit_p1)
        port1_function_select_q <= pfmux_merge(port1_function_select_q,
          wb_dat_i[7:0], wb_sel_i[0], `PFMUX_PORT1_MASK);
      if (do_wr & hit_p3)
        port3_function_select_q <= pfmux_merge(port3_function_select_q,
          wb_dat_i[7:0], wb_sel_i[0], `PFMUX_PORT3_MASK);
      if (do_wr & hit_p4)
        port4_function_select_q <= pfmux_merge(port4_function_select_q,
          wb_dat_i[7:0], wb_sel_i[0], `PFMUX_PORT4_MASK);
    end
  end

  // ==========================================================
  // Pin input synchronisers
  // ==========================================================
  reg  [7:0] p1_meta_q;
  reg  [7:0] p1_sync_q;
  reg  [7:0] p3_meta_q;
  reg  [7:0] p3_sync_q;
  reg  [7:0] p4_meta_q;
  reg  [7:0] p4_sync_q;

  // Logic reads only the second stage; the first may be metastable
  always @(posedge clk_i) begin
    if (rst_i) begin
      p1_meta_q <= `PFMUX_RESET_VAL;
      p1_sync_q <= `PFMUX_RESET_VAL;
      p3_meta_q <= `PFMUX_RESET_VAL;
      p3_sync_q <= `PFMUX_RESET_VAL;
      p4_meta_q <= `PFMUX_RESET_VAL;
      p4_sync_q <= `PFMUX_RESET_VAL;
    end else begin
      p1_meta_q <= p1_pin_i;
      p1_sync_q <= p1_meta_q;
      p3_meta_q <= p3_pin_i;
      p3_sync_q <= p3_meta_q;
      p4_meta_q <= p4_pin_i;
      p4_sync_q <= p4_meta_q;
    end
  end

  // ==========================================================
  // Port 1 mux
  // ==========================================================
  reg  [7:0] p1_o_d;
  reg  [7:0] p1_oe_d;
  reg  [7:0] p3_o_d;
  reg  [7:0] p3_oe_d;
  reg  [7:0] p4_o_d;
  reg  [7:0] p4_oe_d;

  // Ports 0 and 2 belong to the external bus and have no path here
  always @* begin
    // Default: every pin is plain bidirectional I/O
    p1_o_d  = p1_gpio_out_i;
    p1_oe_d = p1_gpio_oe_i;
    // Port 1 pins 0..3 taken only by their peripherals' own enables
    if (timer2_en_i[0]) begin
      p1_o_d[0]  = timer2_out_i[0];
      p1_oe_d[0] = timer2_oe_i[0];
    end
    if (timer2_en_i[1]) begin
      p1_o_d[1]  = timer2_out_i[1];
      p1_oe_d[1] = timer2_oe_i[1];
    end
    if (uart2_en_i[0]) begin
      p1_o_d[2]  = uart2_out_i[0];
      p1_oe_d[2] = uart2_oe_i[0];
    end
    if (uart2_en_i[1]) begin
      p1_o_d[3]  = uart2_out_i[1];
      p1_oe_d[3] = uart2_oe_i[1];
    end
    // Analog pins: output driver released, input goes to the converter
    p1_o_d[7:4]  = p1_o_d[7:4] & ~port1_function_select_q[7:4];
    p1_oe_d[7:4] = p1_oe_d[7:4] & ~port1_function_select_q[7:4];
  end

  // ==========================================================
  // Port 3 mux
  // ==========================================================
  always @* begin
    // Low pins follow peripheral config only, never the select bits
    p3_o_d  = pfmux_pick({2'b00, p3_periph_en_i},
                         {2'b00, p3_periph_out_i}, p3_gpio_out_i);
    p3_oe_d = pfmux_pick({2'b00, p3_periph_en_i},
                         {2'b00, p3_periph_oe_i}, p3_gpio_oe_i);
    // Port 3 pins 6,7: GPIO or I2C, never read/write strobes
    if (port3_function_select_q[`PFMUX_P3_SCL_BIT]) begin
      p3_o_d[7]  = i2c_scl_out_i;
      p3_oe_d[7] = i2c_scl_oe_i;
    end
    if (port3_function_select_q[`PFMUX_P3_SDA_BIT]) begin
      p3_o_d[6]  = i2c_sda_out_i;
      p3_oe_d[6] = i2c_sda_oe_i;
    end
  end

  // ==========================================================
  // Port 4 mux
  // ==========================================================
  always @* begin
    // PWM drives pins 7..3 when selected; pins 2..0 stay port I/O
    p4_o_d  = pfmux_pick({port4_function_select_q[7:3], 3'b000},
                         {pwm_out_i, 3'b000}, p4_gpio_out_i);
    p4_oe_d = p4_gpio_oe_i | {port4_function_select_q[7:3], 3'b000};
  end

  // ==========================================================
  // Output registers
  // ==========================================================

  always @(posedge clk_i) begin
    if (rst_i) begin
      p1_pin_o              <= `PFMUX_RESET_VAL;
      p1_pin_oe_o           <= `PFMUX_RESET_VAL;
      p3_pin_o              <= `PFMUX_RESET_VAL;
      p3_pin_oe_o           <= `PFMUX_RESET_VAL;
      p4_pin_o              <= `PFMUX_RESET_VAL;
      p4_pin_oe_o           <= `PFMUX_RESET_VAL;
    end else begin
      p1_pin_o              <= p1_o_d;
      p1_pin_oe_o           <= p1_oe_d;
      p3_pin_o              <= p3_o_d;
      p3_pin_oe_o           <= p3_oe_d;
      p4_pin_o              <= p4_o_d;
      p4_pin_oe_o           <= p4_oe_d;
    end
  end

  // ==========================================================
  // Core-side inputs
  // ==========================================================
  // The core sees pins only after both sync stages
  always @(posedge clk_i) begin
    if (rst_i) begin
      p1_gpio_in_o          <= `PFMUX_RESET_VAL;
      p3_gpio_in_o          <= `PFMUX_RESET_VAL;
      p4_gpio_in_o          <= `PFMUX_RESET_VAL;
      p1_periph_in_o        <= `PFMUX_P1_IN_RESET;
      analog_input_select_o <= `PFMUX_ANALOG_RESET;
      p3_periph_in_o        <= `PFMUX_P3_IN_RESET;
      i2c_scl_in_o          <= `PFMUX_I2C_IDLE;
      i2c_sda_in_o          <= `PFMUX_I2C_IDLE;
    end else begin
      p1_gpio_in_o          <= p1_sync_q;
      p3_gpio_in_o          <= p3_sync_q;
      p4_gpio_in_o          <= p4_sync_q;
      p1_periph_in_o        <= p1_sync_q[3:0];
      analog_input_select_o <= port1_function_select_q[7:4];
      p3_periph_in_o        <= p3_sync_q[5:0];
      // I2C sees an idle high line until its pin is selected
      i2c_scl_in_o <= port3_function_select_q[`PFMUX_P3_SCL_BIT] ?
                      p3_sync_q[`PFMUX_P3_SCL_BIT] : `PFMUX_I2C_IDLE;
      i2c_sda_in_o <= port3_function_select_q[`PFMUX_P3_SDA_BIT] ?
                      p3_sync_q[`PFMUX_P3_SDA_BIT] : `PFMUX_I2C_IDLE;
    end
  end

endmodule

`default_nettype wire

// File: bench/pfmux_assertions.sv
// Checker for the port function mux bus and pin behaviour
`timescale 1ns/10ps
`default_nettype none
module pfmux_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0]  analog_input_select_o,
  input wire logic [7:0]  p1_pin_oe_o,
  input wire logic [7:0]  p3_pin_o,
  input wire logic [7:0]  p3_pin_oe_o,
  input wire logic [5:0]  p3_periph_en_i,
  input wire logic [5:0]  p3_periph_out_i,
  input wire logic [7:0]  p4_pin_o,
  input wire logic [7:0]  p4_pin_oe_o,
  input wire logic [7:0]  p4_gpio_out_i
);
  // ==========================================
  // Properties
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not answered next cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  chk_sel_reset: assert property (
    $fell(rst_i) |-> analog_input_select_o == 4'h0)
    else $error("select not cleared by reset");
  chk_reset_gpio: assert property (
    $fell(rst_i) |-> p3_pin_oe_o == 8'h0 && p4_pin_oe_o == 8'h0)
    else $error("pins driven after reset");
  chk_analog_hiz: assert property (
    (p1_pin_oe_o[7:4] & analog_input_select_o
     & $past(analog_input_select_o)) == 4'h0)
    else $error("analog pin still driven");
  chk_p4_low_gpio: assert property (
    !$past(rst_i) |-> p4_pin_o[2:0] == $past(p4_gpio_out_i[2:0]))
    else $error("port4 low pins not gpio");
  chk_p3_periph: assert property (
    !$past(rst_i) && $past(p3_periph_en_i[0])
    |-> p3_pin_o[0] == $past(p3_periph_out_i[0]))
    else $error("port3 peripheral not routed");
  cover property (wb_ack_o && wb_dat_o != 32'h0);
  cover property (analog_input_select_o == 4'hf);
  cover property (p4_pin_oe_o[7:3] == 5'h1f);
endmodule
bind pfmux_top pfmux_assertions u_chk (
  .clk_i                 (clk_i),
  .rst_i                 (rst_i),
  .wb_cyc_i              (wb_cyc_i),
  .wb_stb_i              (wb_stb_i),
  .wb_ack_o              (wb_ack_o),
  .wb_dat_o              (wb_dat_o),
  .analog_input_select_o (analog_input_select_o),
  .p1_pin_oe_o           (p1_pin_oe_o),
  .p3_pin_o              (p3_pin_o),
  .p3_pin_oe_o           (p3_pin_oe_o),
  .p3_periph_en_i        (p3_periph_en_i),
  .p3_periph_out_i       (p3_periph_out_i),
  .p4_pin_o              (p4_pin_o),
  .p4_pin_oe_o           (p4_pin_oe_o),
  .p4_gpio_out_i         (p4_gpio_out_i)
);
`default_nettype wire

// File: bench/mcu_port_function_mux_bench.sv
// Self-checking bench for the port function mux
`timescale 1ns/10ps
`default_nettype none
module mcu_port_function_mux_bench;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        i2c_scl_out_i, i2c_scl_oe_i, i2c_sda_out_i, i2c_sda_oe_i;
  logic        i2c_scl_in_o, i2c_sda_in_o;
  logic [1:0]  timer2_en_i, timer2_out_i, timer2_oe_i;
  logic [1:0]  uart2_en_i, uart2_out_i, uart2_oe_i;
  logic [3:0]  wb_sel_i, p1_periph_in_o, analog_input_select_o;
  logic [4:0]  pwm_out_i;
  logic [5:0]  p3_periph_en_i, p3_periph_out_i, p3_periph_oe_i;
  logic [5:0]  p3_periph_in_o;
  logic [7:0]  p1_gpio_out_i, p1_gpio_oe_i, p1_gpio_in_o, p1_pin_i;
  logic [7:0]  p1_pin_o, p1_pin_oe_o, p3_gpio_out_i, p3_gpio_oe_i;
  logic [7:0]  p3_gpio_in_o, p3_pin_i, p3_pin_o, p3_pin_oe_o;
  logic [7:0]  p4_gpio_out_i, p4_gpio_oe_i, p4_gpio_in_o, p4_pin_i;
  logic [7:0]  p4_pin_o, p4_pin_oe_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
  logic [7:0]  idx_t [3] = '{8'h91, 8'h93, 8'h94};
  logic [7:0]  msk_t [3] = '{8'hf0, 8'hc0, 8'hf8};
  int          bad_count = 0;
  int          comparisons = 0;

  pfmux_top dut (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .p1_gpio_out_i(p1_gpio_out_i), .p1_gpio_oe_i(p1_gpio_oe_i),
    .p1_gpio_in_o(p1_gpio_in_o),
    .timer2_en_i(timer2_en_i), .timer2_out_i(timer2_out_i),
    .timer2_oe_i(timer2_oe_i),
    .uart2_en_i(uart2_en_i), .uart2_out_i(uart2_out_i),
    .uart2_oe_i(uart2_oe_i),
    .p1_periph_in_o(p1_periph_in_o),
    .analog_input_select_o(analog_input_select_o),
    .p3_gpio_out_i(p3_gpio_out_i), .p3_gpio_oe_i(p3_gpio_oe_i),
    .p3_gpio_in_o(p3_gpio_in_o),
    .p3_periph_en_i(p3_periph_en_i), .p3_periph_out_i(p3_periph_out_i),
    .p3_periph_oe_i(p3_periph_oe_i), .p3_periph_in_o(p3_periph_in_o),
    .i2c_scl_out_i(i2c_scl_out_i), .i2c_scl_oe_i(i2c_scl_oe_i),
    .i2c_sda_out_i(i2c_sda_out_i), .i2c_sda_oe_i(i2c_sda_oe_i),
    .i2c_scl_in_o(i2c_scl_in_o), .i2c_sda_in_o(i2c_sda_in_o),
    .p4_gpio_out_i(p4_gpio_out_i), .p4_gpio_oe_i(p4_gpio_oe_i),
    .p4_gpio_in_o(p4_gpio_in_o), .pwm_out_i(pwm_out_i),
    .p1_pin_i(p1_pin_i), .p1_pin_o(p1_pin_o), .p1_pin_oe_o(p1_pin_oe_o),
    .p3_pin_i(p3_pin_i), .p3_pin_o(p3_pin_o), .p3_pin_oe_o(p3_pin_oe_o),
    .p4_pin_i(p4_pin_i), .p4_pin_o(p4_pin_o), .p4_pin_oe_o(p4_pin_oe_o)
  );

  always #5 clk_i = ~clk_i;

  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] idx,
                     input logic [3:0] sel, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {22'h0, idx, 2'h0, sel, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic test_done;
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset;
    chk("p4 pins", {p4_pin_oe_o, p4_pin_o}, 16'h0000);
    chk("p3 pins", {p3_pin_oe_o, p3_pin_o}, 16'h00ff);
    chk("p1 oe", p1_pin_oe_o, 8'hf0);
    chk("scl in", i2c_scl_in_o, 1'b1);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, idx_t[i], 4'h1, 32'h0);
      chk("sel reset", rd, 32'h0);
      bus(1'b1, idx_t[i], 4'h1, 32'hffff_ffff);
      bus(1'b0, idx_t[i], 4'h1, 32'h0);
      chk("sel mask", rd, {24'h0, msk_t[i]});
    end
    bus(1'b1, 8'h92, 4'h1, 32'hff);
    bus(1'b0, 8'h92, 4'h1, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, 8'h94, 4'h0, 32'h0);
    bus(1'b0, 8'h94, 4'h1, 32'h0);
    chk("lane off", rd, 32'hf8);
  endtask

  task automatic t_p1;
    @(posedge clk_i);
    p1_gpio_out_i <= 8'h5a;
    p1_gpio_oe_i <= 8'hff;
    {timer2_en_i, timer2_out_i, timer2_oe_i} <= 6'h14;
    {uart2_en_i, uart2_out_i, uart2_oe_i} <= 6'h24;
    p1_pin_i <= 8'hc5;
    settle;
    chk("analog", analog_input_select_o, 4'hf);
    chk("p1 pins", {p1_pin_oe_o, p1_pin_o}, 16'h0603);
    chk("p1 in", {p1_gpio_in_o, p1_periph_in_o}, 12'hc55);
  endtask

  task automatic t_p3;
    @(posedge clk_i);
    p3_gpio_out_i <= 8'h0f;
    p3_gpio_oe_i <= 8'hff;
    p3_periph_en_i <= 6'h03;
    p3_periph_out_i <= 6'h02;
    p3_periph_oe_i <= 6'h01;
    {i2c_scl_out_i, i2c_scl_oe_i, i2c_sda_out_i, i2c_sda_oe_i} <= 4'h6;
    p3_pin_i <= 8'h3c;
    settle;
    chk("p3 pins", {p3_pin_oe_o, p3_pin_o}, 16'hbd4e);
    chk("p3 in", {p3_gpio_in_o, p3_periph_in_o}, 14'h0f3c);
    chk("i2c in", {i2c_scl_in_o, i2c_sda_in_o}, 2'h0);
    bus(1'b1, 8'h93, 4'h1, 32'h0);
    settle;
    chk("p3 gpio", {p3_pin_oe_o, p3_pin_o}, 16'hfd0e);
    chk("i2c idle", {i2c_scl_in_o, i2c_sda_in_o}, 2'h3);
  endtask

  task automatic t_p4;
    @(posedge clk_i);
    pwm_out_i <= 5'h16;
    p4_gpio_out_i <= 8'h05;
    p4_gpio_oe_i <= 8'h03;
    p4_pin_i <= 8'ha1;
    settle;
    chk("p4 pins", {p4_pin_oe_o, p4_pin_o}, 16'hfbb5);
    chk("p4 in", p4_gpio_in_o, 8'ha1);
  endtask

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i,
     p1_gpio_out_i, p1_gpio_oe_i, timer2_en_i, timer2_out_i, timer2_oe_i,
     uart2_en_i, uart2_out_i, uart2_oe_i, p3_gpio_out_i, p3_gpio_oe_i,
     p3_periph_en_i, p3_periph_out_i, p3_periph_oe_i, i2c_scl_out_i,
     i2c_sda_out_i, i2c_sda_oe_i, p4_gpio_out_i, p4_gpio_oe_i,
     p1_pin_i, p3_pin_i, p4_pin_i} = '0;
    pwm_out_i = 5'h1f;
    p3_gpio_out_i = 8'hff;
    i2c_scl_oe_i = 1'b1;
    p1_gpio_oe_i = 8'hf0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    settle;
    t_reset;
    t_regs;
    t_p1;
    t_p3;
    t_p4;
    test_done;
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    test_done;
  end
endmodule
`default_nettype wire
